//--- src/rsv_pkg.sv
package rsv_pkg;

   // ***************************************************************
   // Timebase and supervisor timing
   // ***************************************************************
   localparam int unsigned CLK_HZ         = 125000000;
   localparam int unsigned TICK_HZ        = 1000;
   localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
   localparam int unsigned WDT_SHORT_MS   = 250;
   localparam int unsigned WDT_MID_MS     = 750;
   localparam int unsigned WDT_LONG_MS    = 1750;
   localparam int unsigned RST_TIMEOUT_MS = 250;
   localparam int unsigned MS_W           = 11;

   // ***************************************************************
   // Watchdog period selection codes
   // ***************************************************************
   localparam logic [1:0] WDT_SEL_OFF   = 2'h3;
   localparam logic [1:0] WDT_SEL_SHORT = 2'h2;
   localparam logic [1:0] WDT_SEL_MID   = 2'h1;
   localparam logic [1:0] WDT_SEL_LONG  = 2'h0;

   // ***************************************************************
   // Slave byte layout
   // ***************************************************************
   localparam logic [3:0] ID_ARRAY    = 4'hA;
   localparam logic [3:0] ID_CTRL     = 4'hD;
   localparam logic [2:0] DEV_SELECT  = 3'h7;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [3:0] BIT_LAST    = 4'h7;
   localparam logic [3:0] BIT_ACK     = 4'h8;

   // ***************************************************************
   // Bus engine states, Gray along the write path
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SLAVE = 3'h1,
      ST_ADRH  = 3'h3,
      ST_ADRL  = 3'h2,
      ST_WDATA = 3'h6,
      ST_RDATA = 3'h7,
      ST_WAIT  = 3'h5
   } rsv_state_t;

   // Conditioned bus line events
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } rsv_bus_ev_t;

   // One access seen by the storage side
   typedef struct packed {
      logic        ctrl_space;
      logic [15:0] addr;
      logic [7:0]  data;
   } rsv_access_t;

endpackage : rsv_pkg

//--- src/rsv_line_cond.sv
`timescale 1ns/1ps
module rsv_line_cond
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Raw bus lines
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   // Conditioned events
   output rsv_pkg::rsv_bus_ev_t      ev
);

   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic       scl_q;
   logic       sda_q;

   // ***************************************************************
   // Three-stage sync, second and third must agree
   // ***************************************************************
   // RULE24: sync and filter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
      end
      else
      begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         if (scl_s_q[1] == scl_s_q[2])
            scl_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2])
            sda_q <= sda_s_q[2];
      end
   end

   logic scl_new;
   logic sda_new;
   assign scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
   assign sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;

   // RULE11: edges under high clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ev <= '0;
      else
      begin
         ev.start    <= scl_q & scl_new & sda_q & ~sda_new;
         ev.stop     <= scl_q & scl_new & ~sda_q & sda_new;
         ev.scl_rise <= ~scl_q & scl_new;
         ev.scl_fall <= scl_q & ~scl_new;
         ev.sda      <= sda_new;
      end
   end

endmodule : rsv_line_cond

//--- src/rsv_i2c_supervisor.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Period select 11 off, 10 250ms, 01 750ms, 00 1.75s.
// RULE2: Each START reloads the watchdog to its full period.
// RULE3: Watchdog expiry drives reset for one time-out interval.
// RULE4: START during a reset interval has no effect.
// RULE5: Master follows a lone refresh START with a STOP.
// RULE6: Power-up holds reset until supply good for 250ms.
// RULE7: No array access while power-on reset is active.
// RULE8: Low supply holds reset; release 250ms after recovery.
// RULE9: Low-voltage reset keeps running write unless on battery.
// RULE10: Low-voltage reset drops serial transaction and refuses commands.
// RULE11: SDA changes under high SCL are start or stop.
// RULE12: Ignore all traffic until a valid START.
// RULE13: STOP after read returns to standby.
// RULE14: Release SDA after 8 bits; receiver acks on ninth.
// RULE15: Ack only slave byte 1010111 or 1101111.
// RULE16: Upper nibble selects array or control; select bits 111.
// RULE17: Slave byte bit 0 one reads, zero writes.
// RULE18: Acknowledge every written data byte.
// RULE19: Read continues on ack, stops transmitting on no ack.
// RULE20: Master sends STOP after a no-ack read end.
// RULE21: Optional two-byte address; counter cleared to zero at power-up.
// RULE22: Random read repeats the same target slave byte.
// RULE23: Ignore bus and release SDA during a write cycle.
// RULE24: Bus lines synchronised and filtered before detection.
// RULE25: Timers run from a divided timebase.
module rsv_i2c_supervisor #(
   parameter int unsigned TICK_DIV = rsv_pkg::TICK_DIV
)
(
   // System clock and reset
   input  wire logic         clock,
   input  wire logic         rstn,
   // Oscillator timebase domain
   input  wire logic         osc_clk,
   // Bus pins
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe_n,
   // Supervisor
   input  wire logic         wdt_period_sel_hi,
   input  wire logic         wdt_period_sel_lo,
   input  wire logic         supply_low,
   input  wire logic         on_battery,
   output logic              reset_out_n,
   // Storage side
   input  wire logic         nv_write_busy,
   input  wire logic [7:0]   rd_data,
   output logic              nv_abort,
   output logic              wr_strobe,
   output logic              rd_strobe,
   output logic              commit,
   output rsv_pkg::rsv_access_t acc
);

   // Divider needs at least two states to make a tick
   if (TICK_DIV < 2)
   begin : g_bad_div
      $error("TICK_DIV too small");
   end

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_s_q;
   logic       rst_n;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rst_s_q <= 2'h0;
      else
         rst_s_q <= {rst_s_q[0], 1'b1};
   end
   assign rst_n = rst_s_q[1];

   logic [1:0] orst_s_q;
   logic       orst_n;
   always_ff @(posedge osc_clk or negedge rstn)
   begin
      if (!rstn)
         orst_s_q <= 2'h0;
      else
         orst_s_q <= {orst_s_q[0], 1'b1};
   end
   assign orst_n = orst_s_q[1];

   // ***************************************************************
   // Bus line conditioning
   // ***************************************************************
   rsv_pkg::rsv_bus_ev_t ev;
   rsv_line_cond u_cond (
      .clk    (clock),
      .rst_n  (rst_n),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .ev     (ev)
   );

   // ***************************************************************
   // Start event crossing to the timebase domain (toggle)
   // ***************************************************************
   logic       start_tgl_q;
   logic [2:0] start_s_q;
   logic       hold_n;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         start_tgl_q <= 1'b0;
      else if (ev.start)
         start_tgl_q <= ~start_tgl_q;
   end

   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
         start_s_q <= 3'h0;
      else
         start_s_q <= {start_s_q[1:0], start_tgl_q};
   end

   // ***************************************************************
   // Millisecond tick from divided timebase
   // ***************************************************************
   logic [31:0] div_q;
   logic        tick;
   // RULE25: divided timebase
   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
         div_q <= 32'h0;
      else if (div_q == TICK_DIV - 1)
         div_q <= 32'h0;
      else
         div_q <= div_q + 32'h1;
   end
   assign tick = (div_q == TICK_DIV - 1);

   // Supply and period inputs synchronised to timebase
   logic [2:0] low_s_q;
   logic       low_q;
   logic [1:0] sel_a_q;
   logic [1:0] sel_b_q;
   logic [1:0] sel_c_q;
   logic [1:0] sel_q;
   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
      begin
         low_s_q <= 3'h7;
         low_q   <= 1'b1;
         sel_a_q <= rsv_pkg::WDT_SEL_OFF;
         sel_b_q <= rsv_pkg::WDT_SEL_OFF;
         sel_c_q <= rsv_pkg::WDT_SEL_OFF;
         sel_q   <= rsv_pkg::WDT_SEL_OFF;
      end
      else
      begin
         low_s_q <= {low_s_q[1:0], supply_low};
         if (low_s_q[1] == low_s_q[2])
            low_q <= low_s_q[2];
         sel_a_q <= {wdt_period_sel_hi, wdt_period_sel_lo};
         sel_b_q <= sel_a_q;
         sel_c_q <= sel_b_q;
         if (sel_c_q == sel_b_q)
            sel_q <= sel_c_q;
      end
   end

   // RULE1: period decode
   function automatic logic [10:0] wdt_limit(input logic [1:0] sel);
      case (sel)
         rsv_pkg::WDT_SEL_SHORT: wdt_limit = 11'(rsv_pkg::WDT_SHORT_MS);
         rsv_pkg::WDT_SEL_MID:   wdt_limit = 11'(rsv_pkg::WDT_MID_MS);
         default:                wdt_limit = 11'(rsv_pkg::WDT_LONG_MS);
      endcase
   endfunction : wdt_limit

   // ***************************************************************
   // Reset time-out and watchdog
   // ***************************************************************
   logic [10:0] rto_q;
   logic [10:0] wdt_q;
   logic        rst_active_q;
   logic        wdt_off;
   logic        start_seen;
   assign wdt_off    = (sel_q == rsv_pkg::WDT_SEL_OFF);
   assign start_seen = start_s_q[2] ^ start_s_q[1];

   // RULE6: power-up interval
   // RULE8: low supply holds, then times out
   // RULE3: expiry starts reset interval
   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
      begin
         rto_q        <= 11'(rsv_pkg::RST_TIMEOUT_MS);
         rst_active_q <= 1'b1;
      end
      else if (low_q)
      begin
         rto_q        <= 11'(rsv_pkg::RST_TIMEOUT_MS);
         rst_active_q <= 1'b1;
      end
      else if (rst_active_q)
      begin
         if (tick)
         begin
            if (rto_q <= 11'h1)
               rst_active_q <= 1'b0;
            else
               rto_q <= rto_q - 11'h1;
         end
      end
      else if (!wdt_off && tick && wdt_q <= 11'h1)
      begin
         rto_q        <= 11'(rsv_pkg::RST_TIMEOUT_MS);
         rst_active_q <= 1'b1;
      end
   end

   // RULE2: start reloads
   // RULE4: no effect during reset interval
   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
         wdt_q <= 11'(rsv_pkg::WDT_LONG_MS);
      else if (rst_active_q || wdt_off)
         wdt_q <= wdt_limit(sel_q);
      else if (start_seen)
         wdt_q <= wdt_limit(sel_q);
      else if (tick)
         wdt_q <= (wdt_q <= 11'h1) ? wdt_limit(sel_q) : wdt_q - 11'h1;
   end

   always_ff @(posedge osc_clk or negedge orst_n)
   begin
      if (!orst_n)
         reset_out_n <= 1'b0;
      else
         reset_out_n <= ~rst_active_q;
   end

   // Reset and low supply back to the bus domain
   logic [2:0] rstact_s_q;
   logic [2:0] lvr_s_q;
   logic       block_q;
   logic       lvr_q;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstact_s_q <= 3'h7;
         lvr_s_q    <= 3'h7;
         block_q    <= 1'b1;
         lvr_q      <= 1'b1;
      end
      else
      begin
         rstact_s_q <= {rstact_s_q[1:0], rst_active_q};
         lvr_s_q    <= {lvr_s_q[1:0], supply_low};
         if (rstact_s_q[1] == rstact_s_q[2])
            block_q <= rstact_s_q[2];
         if (lvr_s_q[1] == lvr_s_q[2])
            lvr_q <= lvr_s_q[2];
      end
   end

   // RULE9: only abort on battery
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         nv_abort <= 1'b0;
      else
         nv_abort <= lvr_q & on_battery & nv_write_busy;
   end

   // ***************************************************************
   // Bus engine
   // ***************************************************************
   rsv_pkg::rsv_state_t st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic        ctrl_q;
   logic        rd_q;
   logic        wrote_q;
   logic [15:0] addr_q;
   logic        deny;
   logic [7:0]  byte_in;

   // RULE7: no access during power-on reset
   // RULE10: low voltage drops transaction
   // RULE23: ignore during write cycle
   assign deny    = block_q | lvr_q | nv_write_busy;
   assign byte_in = {sh_q[6:0], ev.sda};

   function automatic logic id_match(input logic [7:0] b);
      id_match = (b[7:4] == rsv_pkg::ID_ARRAY || b[7:4] == rsv_pkg::ID_CTRL)
                 && b[3:1] == rsv_pkg::DEV_SELECT;
   endfunction : id_match

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q     <= rsv_pkg::ST_IDLE;
         bit_q    <= 4'h0;
         sh_q     <= 8'h0;
         ctrl_q   <= 1'b0;
         rd_q     <= 1'b0;
         wrote_q  <= 1'b0;
         sda_oe_n <= 1'b1;
         sda_out  <= 1'b0;
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         commit   <= 1'b0;
         // RULE21: counter cleared at power-up
         addr_q   <= rsv_pkg::ADDR_RESET;
      end
      else
      begin
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         commit    <= 1'b0;
         if (deny)
         begin
            st_q     <= rsv_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
         end
         // RULE12: start opens a transaction
         else if (ev.start)
         begin
            st_q     <= rsv_pkg::ST_SLAVE;
            // SCL fall closing the START wraps the count to bit 0
            bit_q    <= '1;
            wrote_q  <= 1'b0;
            sda_oe_n <= 1'b1;
         end
         // RULE13: stop to standby
         else if (ev.stop)
         begin
            commit   <= wrote_q & (st_q == rsv_pkg::ST_WDATA);
            st_q     <= rsv_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
         end
         else if (st_q != rsv_pkg::ST_IDLE && st_q != rsv_pkg::ST_WAIT)
         begin
            // Sampling would corrupt the outgoing read byte
            if (ev.scl_rise && bit_q <= rsv_pkg::BIT_LAST
                && st_q != rsv_pkg::ST_RDATA)
               sh_q <= byte_in;
            // Ack sampled from master during read
            if (ev.scl_rise && bit_q == rsv_pkg::BIT_ACK
                && st_q == rsv_pkg::ST_RDATA)
               // RULE19: continue only on ack
               if (ev.sda)
               begin
                  st_q <= rsv_pkg::ST_WAIT;
               end
            if (ev.scl_fall)
            begin
               sda_oe_n <= 1'b1;
               if (bit_q == rsv_pkg::BIT_LAST)
               begin
                  bit_q <= rsv_pkg::BIT_ACK;
                  // RULE14: ack ninth clock
                  case (st_q)
                     rsv_pkg::ST_SLAVE:
                     begin
                        // RULE15: address compare
                        if (id_match(sh_q))
                        begin
                           sda_oe_n <= 1'b0;
                           // RULE16: target select
                           ctrl_q <= (sh_q[7:4] == rsv_pkg::ID_CTRL);
                           // RULE17: direction bit
                           rd_q   <= sh_q[0];
                        end
                        else
                           st_q <= rsv_pkg::ST_WAIT;
                     end
                     rsv_pkg::ST_ADRH:
                     begin
                        sda_oe_n <= 1'b0;
                        addr_q[15:8] <= sh_q;
                     end
                     rsv_pkg::ST_ADRL:
                     begin
                        sda_oe_n <= 1'b0;
                        addr_q[7:0] <= sh_q;
                     end
                     rsv_pkg::ST_WDATA:
                     begin
                        // RULE18: ack data bytes
                        sda_oe_n  <= 1'b0;
                        wr_strobe <= 1'b1;
                        wrote_q   <= 1'b1;
                     end
                     default:
                        sda_oe_n <= 1'b1;
                  endcase
               end
               else if (bit_q == rsv_pkg::BIT_ACK)
               begin
                  bit_q <= 4'h0;
                  case (st_q)
                     rsv_pkg::ST_SLAVE:
                        st_q <= rd_q ? rsv_pkg::ST_RDATA : rsv_pkg::ST_ADRH;
                     rsv_pkg::ST_ADRH:
                        st_q <= rsv_pkg::ST_ADRL;
                     rsv_pkg::ST_ADRL:
                        st_q <= rsv_pkg::ST_WDATA;
                     // Step only after acc has shown the written address
                     rsv_pkg::ST_WDATA:
                        addr_q <= addr_q + 16'h1;
                     default:
                        st_q <= st_q;
                  endcase
                  if (st_q == rsv_pkg::ST_RDATA
                      || (st_q == rsv_pkg::ST_SLAVE && rd_q))
                  begin
                     rd_strobe <= 1'b1;
                     // Open drain: the pin is only ever pulled low
                     sda_out   <= 1'b0;
                     sh_q      <= {rd_data[6:0], 1'b0};
                     sda_oe_n  <= ~rd_data[7] ? 1'b0 : 1'b1;
                     addr_q    <= addr_q + 16'h1;
                  end
               end
               else
               begin
                  bit_q <= bit_q + 4'h1;
                  if (st_q == rsv_pkg::ST_RDATA)
                  begin
                     sda_oe_n <= sh_q[7] ? 1'b1 : 1'b0;
                     sh_q     <= {sh_q[6:0], 1'b0};
                  end
               end
            end
         end
      end
   end

   // Storage-side access view, registered from the engine state every cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         acc <= '0;
      else
      begin
         acc.ctrl_space <= ctrl_q;
         acc.addr       <= addr_q;
         acc.data       <= sh_q;
      end
   end

endmodule : rsv_i2c_supervisor

//--- dv/rsv_i2c_supervisor_asserts.sv
`timescale 1ns/1ps
module rsv_i2c_supervisor_asserts
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rstn,
   // Watched ports
   input  wire logic scl_in,
   input  wire logic sda_out,
   input  wire logic sda_oe_n,
   input  wire logic supply_low,
   input  wire logic on_battery,
   input  wire logic nv_write_busy,
   input  wire logic reset_out_n,
   input  wire logic nv_abort
);
   // Crossing through the timebase domain takes a few slow edges
   localparam int LAT = 40;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ***************************************************************
   // Sequences
   // ***************************************************************
   sequence s_scl_hi;
      scl_in[*8];
   endsequence
   sequence s_batt_busy;
      (supply_low && on_battery && nv_write_busy)[*2];
   endsequence
   // ***************************************************************
   // Properties
   // ***************************************************************
   a_drive_low: assert property (!sda_oe_n |-> !sda_out)
      else $error("sda driven high");
   a_scl_steady: assert property (s_scl_hi |=> $stable(sda_oe_n))
      else $error("sda moved under high scl");
   a_rst_quiet: assert property ((!reset_out_n)[*4] |-> sda_oe_n)
      else $error("bus answered during reset");
   a_lv_quiet: assert property (supply_low[*6] |-> sda_oe_n)
      else $error("bus answered under low supply");
   a_busy_quiet: assert property (nv_write_busy[*6] |-> sda_oe_n)
      else $error("bus answered during write cycle");
   a_lv_reset: assert property ($rose(supply_low) |-> ##[1:LAT] !reset_out_n)
      else $error("no reset on low supply");
   a_abort_on: assert property (s_batt_busy |-> ##[0:LAT] nv_abort)
      else $error("write not aborted on battery");
   a_abort_off: assert property ($fell(on_battery) |-> ##[1:LAT] !nv_abort)
      else $error("write aborted off battery");
endmodule : rsv_i2c_supervisor_asserts

bind rsv_i2c_supervisor rsv_i2c_supervisor_asserts u_chk (.clock, .rstn,
   .scl_in, .sda_out, .sda_oe_n, .supply_low, .on_battery, .nv_write_busy,
   .reset_out_n, .nv_abort);

//--- dv/rsv_host_model.sv
`timescale 1ns/1ps
module rsv_host_model
(
   // Clock
   input  wire logic clock,
   // Bus
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // Slow quarter bit so the slave's filtered sampling keeps up
   localparam int Q = 20;
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic q;
      repeat (Q) @(posedge clock);
      #1;
   endtask : q
   task automatic bit_out(input logic b);
      sda_drv = b;
      q; scl = 1'b1; q; q; scl = 1'b0; q;
   endtask : bit_out
   task automatic bit_in(output logic b);
      sda_drv = 1'b1;
      q; scl = 1'b1; q; b = sda_line; q; scl = 1'b0; q;
   endtask : bit_in
   task automatic start;
      sda_drv = 1'b1;
      q; scl = 1'b1; q; sda_drv = 1'b0; q; scl = 1'b0; q;
   endtask : start
   task automatic stop;
      sda_drv = 1'b0;
      q; scl = 1'b1; q; sda_drv = 1'b1; q;
   endtask : stop
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = !b;
   endtask : wr_byte
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(!ack);
   endtask : rd_byte
endmodule : rsv_host_model

//--- dv/test_rsv_i2c_supervisor.sv
`timescale 1ns/1ps
module test_rsv_i2c_supervisor;
   logic clock = 1'b0, rstn = 1'b0, osc_clk = 1'b0;
   logic scl, sda_drv, sda_line, sda_out, sda_oe_n, sel_hi = 1'b1;
   logic sel_lo = 1'b1, supply_low = 1'b0, on_battery = 1'b0;
   logic nv_write_busy = 1'b0, reset_out_n, nv_abort, wr_strobe;
   logic rd_strobe, commit, wr_q = 1'b0;
   rsv_pkg::rsv_access_t acc, last_acc;
   int cyc = 0, n_wr = 0, n_rd = 0, n_commit = 0, n_mismatch = 0;
   int n_compared = 0;
   always #4 clock = ~clock;
   initial #7 forever #15 osc_clk = ~osc_clk;
   assign sda_line = sda_drv & (sda_oe_n | sda_out);
   rsv_host_model m (.clock(clock), .sda_line(sda_line), .scl(scl),
      .sda_drv(sda_drv));
   rsv_i2c_supervisor #(.TICK_DIV(4)) dut (.clock(clock), .rstn(rstn),
      .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wdt_period_sel_hi(sel_hi),
      .wdt_period_sel_lo(sel_lo), .supply_low(supply_low),
      .on_battery(on_battery), .reset_out_n(reset_out_n),
      .nv_write_busy(nv_write_busy), .rd_data(8'hC3), .nv_abort(nv_abort),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .commit(commit),
      .acc(acc));
   always @(posedge clock)
   begin
      cyc++;
      wr_q <= wr_strobe;
      if (wr_q) last_acc <= acc;
      n_wr += wr_strobe;
      n_rd += rd_strobe;
      n_commit += commit;
      if (cyc == 100000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_rst(input logic lvl, input int lim);
      for (int i = 0; i < lim && reset_out_n !== lvl; i++) @(posedge clock);
      #1;
   endtask : wait_rst
   task automatic probe(input logic [7:0] sb);
      logic ak;
      m.start; m.wr_byte(sb, ak); m.stop;
      chk("nack", 0, ak);
   endtask : probe
   task automatic refresh;
      m.start; m.stop;
   endtask : refresh
   task automatic t_por;
      int t0;
      t0 = cyc;
      probe(8'hAE);
      wait_rst(1'b1, 6000);
      chk("por len", 1, (cyc - t0) > 3600 && (cyc - t0) < 4000);
      $display("test por done");
   endtask : t_por
   task automatic t_wr(input logic [7:0] sb, input logic [15:0] a,
                       input logic [7:0] d);
      logic ak0, ak1, ak2, ak3;
      int w0, c0;
      w0 = n_wr; c0 = n_commit;
      m.start; m.wr_byte(sb, ak0); m.wr_byte(a[15:8], ak1);
      m.wr_byte(a[7:0], ak2); m.wr_byte(d, ak3); m.stop;
      repeat (20) @(posedge clock);
      chk("acks", 4'hF, {ak0, ak1, ak2, ak3});
      chk("writes", w0 + 1, n_wr);
      chk("commit", c0 + 1, n_commit);
      chk("acc", {sb[7:4] == rsv_pkg::ID_CTRL, a, d}, last_acc);
      $display("test write %h done", sb);
   endtask : t_wr
   task automatic t_bad;
      logic [7:0] bad [3] = '{8'hA0, 8'hBE, 8'h5E};
      foreach (bad[i]) probe(bad[i]);
      $display("test bad address done");
   endtask : t_bad
   task automatic t_rd;
      logic ak, ak0, ak1, ak2;
      logic [7:0] d0, d1;
      int r0;
      r0 = n_rd;
      // dummy write and read name the same target
      m.start; m.wr_byte(8'hAE, ak0); m.wr_byte(8'h00, ak1);
      m.wr_byte(8'h10, ak2);
      m.start; m.wr_byte(8'hAF, ak); m.rd_byte(1'b1, d0);
      m.rd_byte(1'b0, d1); m.stop;
      chk("rd ack", 4'hF, {ak0, ak1, ak2, ak});
      chk("rd addr", 16'h0012, acc.addr);
      chk("rd data", 16'hC3C3, {d0, d1});
      chk("rd loads", r0 + 2, n_rd);
      probe(8'hA0);
      $display("test read done");
   endtask : t_rd
   task automatic t_wdt;
      int t0;
      {sel_hi, sel_lo} = rsv_pkg::WDT_SEL_SHORT;
      refresh;
      repeat (3) begin repeat (2000) @(posedge clock); #1 refresh; end
      chk("wdt kept", 1, reset_out_n);
      t0 = cyc; wait_rst(1'b0, 5000);
      chk("wdt 250", 1, (cyc - t0) > 3500 && (cyc - t0) < 4000);
      t0 = cyc; repeat (1000) @(posedge clock); #1 refresh;
      wait_rst(1'b1, 5000);
      chk("wdt pulse", 1, (cyc - t0) > 3500 && (cyc - t0) < 4000);
      {sel_hi, sel_lo} = rsv_pkg::WDT_SEL_OFF; refresh;
      repeat (5000) @(posedge clock);
      chk("wdt off", 1, reset_out_n);
      #1 {sel_hi, sel_lo} = rsv_pkg::WDT_SEL_MID; refresh;
      t0 = cyc; wait_rst(1'b0, 13000);
      chk("wdt 750", 1, (cyc - t0) > 11000 && (cyc - t0) < 11500);
      wait_rst(1'b1, 5000);
      {sel_hi, sel_lo} = rsv_pkg::WDT_SEL_LONG; refresh;
      repeat (15000) @(posedge clock);
      chk("wdt long", 1, reset_out_n);
      #1 {sel_hi, sel_lo} = rsv_pkg::WDT_SEL_OFF; refresh;
      $display("test watchdog done");
   endtask : t_wdt
   task automatic t_lvr;
      int t0;
      supply_low = 1'b1; repeat (50) @(posedge clock);
      chk("lv reset", 0, reset_out_n);
      #1 probe(8'hAE);
      on_battery = 1'b1; nv_write_busy = 1'b1; repeat (50) @(posedge clock);
      chk("abort", 1, nv_abort);
      #1 on_battery = 1'b0; repeat (50) @(posedge clock);
      chk("no abort", 0, nv_abort);
      #1 nv_write_busy = 1'b0; repeat (2000) @(posedge clock);
      chk("lv held", 0, reset_out_n);
      #1 supply_low = 1'b0; t0 = cyc; wait_rst(1'b1, 5000);
      chk("lv release", 1, (cyc - t0) > 3600 && (cyc - t0) < 4000);
      nv_write_busy = 1'b1; probe(8'hAE); nv_write_busy = 1'b0;
      $display("test low voltage done");
   endtask : t_lvr
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (16) @(posedge clock);
      #1 rstn = 1'b1;
      t_por;
      t_wr(8'hAE, 16'h1234, 8'h5A);
      t_wr(8'hDE, 16'h0005, 8'h33);
      t_bad;
      t_rd;
      t_wdt;
      t_lvr;
      tally_and_finish;
   end
endmodule : test_rsv_i2c_supervisor
